/* File: include/sdc_pkg.sv */
// Purpose: shared constants for the synthesizer control byte block
// Assumes: serial stream is shifted msb first
// Notes: control byte bit positions and frame lengths live here
package sdc_pkg;
   // control byte field positions
   localparam int CB_SEC_STBY = 0;
   localparam int CB_MAIN_STBY = 1;
   localparam int CB_OSC_STBY = 2;
   localparam int CB_SEC_FLOAT = 3;
   localparam int CB_MAIN_FLOAT = 4;
   localparam int CB_OUT_C = 5;
   localparam int CB_OUT_B = 6;
   localparam int CB_OUT_A = 7;
   // power-up value: both loops in standby, bit 6 low
   localparam logic [7:0] CB_RESET = 8'h03;
   // frame lengths in serial clocks
   localparam logic [5:0] FRAME_SHORT = 6'h08;
   localparam logic [5:0] FRAME_LONG = 6'h20;
   // address of the control byte in a long frame, arbitrary choice
   localparam logic [3:0] CB_ADDR = 4'h0;
   // lock window in system clock cycles
   localparam int LOCK_WIN_CYC = 32;
endpackage : sdc_pkg

/* File: design/sdc_ctl.sv */
// Purpose: control byte register, serial port and detector output logic
// Assumes: divided reference and vco strobes are one-cycle pulses on i_clk
// Notes: serial pins are oversampled; sclk must be slower than i_clk / 4
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] mode high and pol low: positive polarity
// [R2] positive: lead low pulse, lag high
// [R3] pol high inverts detector pulse sense when mode high
// [R4] secondary standby floats secondary detector
// [R5] secondary float bit floats, counters run
// [R6] converter outputs hold their 8-bit codes
// [R7] accept 8 or 32 clock frames
// [R8] 8-clock frame is data byte only
// [R9] host sends address in 32-clock frame
// [R10] frame end loads byte, nothing else
// [R11] bit 7 drives output A when selected
// [R12] bit 7 ignored when A not selected
// [R13] mode low: output B from bit 6/standby
// [R14] mode high: bit 6 picks reference
// [R15] bit 5: output C float or low
// [R16] main float bit floats both main outputs
// [R17] main float change waits for pulse end
// [R18] locked stays locked until window exceeded; the code also clears lock when main standby is set
// [R19] unlocked stays unlocked while floating
// [R20] secondary float change waits for pulse end
// [R21] shifting never alters register mid-frame
module sdc_ctl
   import sdc_pkg::*;
#(
   parameter int LOCK_WIN = LOCK_WIN_CYC
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // serial port pins
   input wire logic i_sclk,
   input wire logic i_sdata,
   input wire logic i_enb_n,
   // strap pins
   input wire logic i_mode,
   input wire logic i_sec_pol,
   // from other registers
   input wire logic [1:0] i_out_a_sel,
   input wire logic i_out_a_alt,
   input wire logic [7:0] i_dac1_code,
   input wire logic [7:0] i_dac2_code,
   // divided loop strobes
   input wire logic i_main_vco,
   input wire logic i_main_ref,
   input wire logic i_secondary_divided_vco,
   input wire logic i_secondary_divided_reference,
   // secondary detector pin
   output logic o_secondary_detector_output,
   output logic o_secondary_detector_output_oe,
   // main detector pins
   output logic o_main_detector_high_current,
   output logic o_main_detector_high_current_oe,
   output logic o_main_detector_low_current,
   output logic o_main_detector_low_current_oe,
   output logic o_main_lock,
   // general purpose pins and reference select
   output logic o_out_a,
   output logic o_out_b,
   output logic o_out_b_oe,
   output logic o_out_c,
   output logic o_out_c_oe,
   output logic o_ext_ref_sel,
   // converter codes
   output logic [7:0] o_dac1_level,
   output logic [7:0] o_dac2_level
);

   // synchronisers for pins: first stage feeds only the second
   logic [4:0] s1_reg, s2_reg, s3_reg;
   // serial state
   logic [31:0] sr_reg, sr_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [7:0] ctrl_reg, ctrl_next;
   // detector state
   logic sec_lead_reg, sec_lead_next, sec_lag_reg, sec_lag_next;
   logic main_lead_reg, main_lead_next, main_lag_reg, main_lag_next;
   logic sec_fl_reg, sec_fl_next, main_fl_reg, main_fl_next;
   logic [15:0] err_reg, err_next;
   logic lock_reg, lock_next;
   // output next values
   logic sd_o, sd_oe, mh_o, mh_oe, a_o, b_o, b_oe, c_oe, xr_o;

   logic sclk_s, enb_s, mode_s, pol_s, sclk_rise, frame_end, enb_act;
   logic sec_busy, main_busy, inv;

   assign sclk_s = s2_reg[0];
   assign enb_s = s2_reg[2];
   assign mode_s = s2_reg[3];
   assign pol_s = s2_reg[4];
   // edges taken between stage two and stage three only
   assign sclk_rise = sclk_s & ~s3_reg[0];
   assign frame_end = enb_s & ~s3_reg[2];
   assign enb_act = ~enb_s;
   assign sec_busy = sec_lead_reg | sec_lag_reg;
   assign main_busy = main_lead_reg | main_lag_reg;
   // polarity defaults positive when mode is low
   assign inv = mode_s & pol_s; // [R1] [R3]

   // next-state logic for port, register and detectors
   always_comb
   begin
      sr_next = sr_reg;
      cnt_next = cnt_reg;
      ctrl_next = ctrl_reg;
      if (enb_act && sclk_rise)
      begin
         // only the shifter and bit counter move mid-frame
         sr_next = {sr_reg[30:0], s2_reg[1]}; // [R21]
         cnt_next = (cnt_reg == 6'h3f) ? cnt_reg : cnt_reg + 6'h01;
      end
      if (frame_end)
      begin
         cnt_next = 6'h00;
         if (cnt_reg == FRAME_SHORT)
            ctrl_next = sr_reg[7:0]; // [R7] [R8] [R10]
         else if (cnt_reg == FRAME_LONG && sr_reg[3:0] == CB_ADDR)
            ctrl_next = sr_reg[31:24]; // [R7] [R9] [R10]
      end
      // phase detector flip-flops clear when both have fired
      sec_lead_next = sec_lead_reg | i_secondary_divided_vco;
      sec_lag_next = sec_lag_reg | i_secondary_divided_reference;
      if (sec_lead_next && sec_lag_next)
      begin
         sec_lead_next = 1'b0;
         sec_lag_next = 1'b0;
      end
      main_lead_next = main_lead_reg | i_main_vco;
      main_lag_next = main_lag_reg | i_main_ref;
      if (main_lead_next && main_lag_next)
      begin
         main_lead_next = 1'b0;
         main_lag_next = 1'b0;
      end
      // float bits only take hold between correction pulses
      sec_fl_next = sec_busy ? sec_fl_reg : ctrl_reg[CB_SEC_FLOAT]; // [R20]
      main_fl_next = main_busy ? main_fl_reg : ctrl_reg[CB_MAIN_FLOAT]; // [R17]
      // lock: pulse width within window; detector runs even when floated
      err_next = main_busy ? ((err_reg == 16'hffff) ? err_reg : err_reg + 16'h0001) : 16'h0000;
      if (err_reg >= 16'(LOCK_WIN))
         lock_next = 1'b0; // [R18]
      // a float bit on its way in counts too, so leaving standby floated cannot raise lock
      else if (!main_busy && (main_fl_reg || main_fl_next))
         lock_next = lock_reg; // [R19]
      else if (!main_busy)
         lock_next = 1'b1;
      else
         lock_next = lock_reg;
      if (ctrl_reg[CB_MAIN_STBY])
         lock_next = 1'b0;
      // secondary pin: drive only during a pulse, never when floated
      sd_oe = sec_busy & ~sec_fl_reg & ~ctrl_reg[CB_SEC_STBY]; // [R4] [R5]
      sd_o = sec_lead_reg ? inv : ~inv; // [R2] [R3]
      // main pins both follow the same gated detector
      mh_oe = main_busy & ~main_fl_reg & ~ctrl_reg[CB_MAIN_STBY]; // [R16]
      mh_o = main_lead_reg ? inv : ~inv;
      // output A: bit 7 only when selected as general purpose
      a_o = (i_out_a_sel == 2'b00) ? ctrl_reg[CB_OUT_A] : i_out_a_alt; // [R11] [R12]
      // output B is meaningless with mode high, so left floating
      b_oe = ~mode_s & ~ctrl_reg[CB_MAIN_STBY]; // [R13]
      b_o = ctrl_reg[CB_OUT_B];
      xr_o = mode_s & ctrl_reg[CB_OUT_B]; // [R14]
      c_oe = ~ctrl_reg[CB_OUT_C]; // [R15]
   end

   // register every group; outputs straight from flops
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s1_reg <= 5'h04;
         s2_reg <= 5'h04;
         s3_reg <= 5'h04;
         sr_reg <= 32'h0;
         cnt_reg <= 6'h00;
         ctrl_reg <= CB_RESET;
         sec_lead_reg <= 1'b0;
         sec_lag_reg <= 1'b0;
         main_lead_reg <= 1'b0;
         main_lag_reg <= 1'b0;
         sec_fl_reg <= 1'b0;
         main_fl_reg <= 1'b0;
         err_reg <= 16'h0000;
         lock_reg <= 1'b0;
         o_secondary_detector_output <= 1'b0;
         o_secondary_detector_output_oe <= 1'b0;
         o_main_detector_high_current <= 1'b0;
         o_main_detector_high_current_oe <= 1'b0;
         o_main_detector_low_current <= 1'b0;
         o_main_detector_low_current_oe <= 1'b0;
         o_main_lock <= 1'b0;
         o_out_a <= 1'b0;
         o_out_b <= 1'b0;
         o_out_b_oe <= 1'b0;
         o_out_c <= 1'b0;
         o_out_c_oe <= 1'b0;
         o_ext_ref_sel <= 1'b0;
         o_dac1_level <= 8'h00;
         o_dac2_level <= 8'h00;
      end
      else
      begin
         s1_reg <= {i_sec_pol, i_mode, i_enb_n, i_sdata, i_sclk};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         sr_reg <= sr_next;
         cnt_reg <= cnt_next;
         ctrl_reg <= ctrl_next;
         sec_lead_reg <= sec_lead_next;
         sec_lag_reg <= sec_lag_next;
         main_lead_reg <= main_lead_next;
         main_lag_reg <= main_lag_next;
         sec_fl_reg <= sec_fl_next;
         main_fl_reg <= main_fl_next;
         err_reg <= err_next;
         lock_reg <= lock_next;
         o_secondary_detector_output <= sd_o;
         o_secondary_detector_output_oe <= sd_oe;
         o_main_detector_high_current <= mh_o;
         o_main_detector_high_current_oe <= mh_oe;
         o_main_detector_low_current <= mh_o;
         o_main_detector_low_current_oe <= mh_oe;
         o_main_lock <= lock_reg;
         o_out_a <= a_o;
         o_out_b <= b_o;
         o_out_b_oe <= b_oe;
         o_out_c <= 1'b0;
         o_out_c_oe <= c_oe;
         o_ext_ref_sel <= xr_o;
         o_dac1_level <= i_dac1_code; // [R6]
         o_dac2_level <= i_dac2_code; // [R6]
      end
   end

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence short_frame_done;
      frame_end && cnt_reg == FRAME_SHORT;
   endsequence

   sequence long_frame_done;
      frame_end && cnt_reg == FRAME_LONG && sr_reg[3:0] == CB_ADDR;
   endsequence

   chk_short_load: assert property (short_frame_done |=> ctrl_reg == $past(sr_reg[7:0])) // [R8]
      else $error("short frame not loaded");
   chk_long_load: assert property (long_frame_done |=> ctrl_reg == $past(sr_reg[31:24])) // [R7]
      else $error("long frame not loaded");
   chk_mid_frame: assert property (!frame_end |=> $stable(ctrl_reg)) // [R21]
      else $error("register changed mid-frame");
   chk_sec_standby: assert property (ctrl_reg[CB_SEC_STBY] |=> !o_secondary_detector_output_oe) // [R4]
      else $error("secondary driven in standby");
   chk_sec_float: assert property (sec_fl_reg |=> !o_secondary_detector_output_oe) // [R5]
      else $error("secondary driven while floated");
   chk_sec_hold: assert property (sec_busy |=> sec_fl_reg == $past(sec_fl_reg)) // [R20]
      else $error("secondary float changed mid-pulse");
   chk_main_hold: assert property (main_busy |=> main_fl_reg == $past(main_fl_reg)) // [R17]
      else $error("main float changed mid-pulse");
   chk_main_float: assert property (main_fl_reg |=> !o_main_detector_high_current_oe && !o_main_detector_low_current_oe) // [R16]
      else $error("main driven while floated");
   chk_sec_sense: assert property (sec_lead_reg && sd_oe && !(mode_s && pol_s) |=> !o_secondary_detector_output) // [R2]
      else $error("secondary lead pulse wrong sense");
   chk_unlock_stay: assert property (main_fl_reg && !lock_reg |=> !lock_reg) // [R19]
      else $error("lock rose while floated");
   chk_out_c: assert property (ctrl_reg[CB_OUT_C] |=> !o_out_c_oe) // [R15]
      else $error("output c driven when floated");

endmodule : sdc_ctl
`default_nettype wire

/* File: tb/sdc_host.sv */
// Purpose: host model driving the serial control port
// Assumes: sclk stands low between frames
// Notes: data shows the inverse of its last bit once released
`timescale 1ns/1ns
`default_nettype none
module sdc_host
(
   // serial pins
   output logic o_sclk,
   output logic o_sdata,
   output logic o_enb_n
);
   // idle levels at time zero
   initial
   begin
      o_sclk = 1'b0;
      o_sdata = 1'b0;
      o_enb_n = 1'b1;
   end
   // one enable frame, msb first, 160 ns sclk
   task automatic send(input logic [31:0] bits, input int n);
      int i;
      #3 o_enb_n = 1'b0;
      for (i = n - 1; i >= 0; i--)
      begin
         o_sdata = bits[i];
         #80 o_sclk = 1'b1;
         #80 o_sclk = 1'b0;
      end
      o_sdata = ~o_sdata; // stale data must not look valid
      #80 o_enb_n = 1'b1;
   endtask : send
endmodule : sdc_host
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the control byte block
// Assumes: host model owns the serial pins
// Notes: strobes, straps and codes change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sdc_pkg::*;
   logic clk, rst_n, mode, pol, alt;
   logic [1:0] a_sel;
   logic [3:0] stb;
   logic [7:0] d1, d2, l1, l2;
   logic sclk, sdata, enb_n, s_q, s_oe, h_q, h_oe, l_q, l_oe, lock;
   logic oa, ob, ob_oe, oc, oc_oe, xref;
   int mismatches = 0;
   int check_count = 0;
   // far side of the serial port and the block itself
   sdc_host i_host (.o_sclk(sclk), .o_sdata(sdata), .o_enb_n(enb_n));
   sdc_ctl i_dut (.i_clk(clk), .i_resetn(rst_n), .i_sclk(sclk), .i_sdata(sdata), .i_enb_n(enb_n),
      .i_mode(mode), .i_sec_pol(pol), .i_out_a_sel(a_sel), .i_out_a_alt(alt), .i_dac1_code(d1),
      .i_dac2_code(d2), .i_main_vco(stb[0]), .i_main_ref(stb[1]), .i_secondary_divided_vco(stb[2]),
      .i_secondary_divided_reference(stb[3]), .o_secondary_detector_output(s_q),
      .o_secondary_detector_output_oe(s_oe), .o_main_detector_high_current(h_q),
      .o_main_detector_high_current_oe(h_oe), .o_main_detector_low_current(l_q),
      .o_main_detector_low_current_oe(l_oe), .o_main_lock(lock), .o_out_a(oa), .o_out_b(ob),
      .o_out_b_oe(ob_oe), .o_out_c(oc), .o_out_c_oe(oc_oe), .o_ext_ref_sel(xref),
      .o_dac1_level(l1), .o_dac2_level(l2));
   // compare and count
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // frames, then let the byte reach the pins
   task automatic wr(input logic [7:0] b);
      i_host.send({24'h0, b}, 8);
      repeat (8) @(negedge clk);
   endtask : wr
   task automatic lw(input logic [7:0] b, input logic [3:0] a);
      i_host.send({b, 20'h0, a}, 32);
      repeat (8) @(negedge clk);
   endtask : lw
   // one-cycle divider strobe, then output settles
   task automatic pls(input int k);
      @(negedge clk) stb[k] = 1'b1;
      @(negedge clk) stb[k] = 1'b0;
      repeat (3) @(negedge clk);
   endtask : pls
   task automatic t_reset;
      chk("out_b_oe", 8'(ob_oe), 8'h0);
      chk("sec_oe", 8'(s_oe), 8'h0);
      chk("out_c", 8'({oc_oe, oc}), 8'h2);
      $display("test reset done");
   endtask : t_reset
   task automatic t_pins;
      wr(8'h40);
      chk("out_b", 8'({ob_oe, ob}), 8'h3);
      chk("out_c", 8'({oc_oe, oc}), 8'h2);
      wr(8'h22);
      chk("out_b_oe", 8'(ob_oe), 8'h0);
      chk("out_c_oe", 8'(oc_oe), 8'h0);
      lw(8'h80, CB_ADDR);
      chk("out_a", 8'(oa), 8'h1);
      chk("out_c", 8'({oc_oe, oc}), 8'h2);
      lw(8'h00, 4'h1); // wrong address must be dropped
      chk("out_a", 8'(oa), 8'h1);
      a_sel = 2'h1;
      repeat (6) @(negedge clk);
      chk("out_a_alt", 8'(oa), 8'h0);
      a_sel = 2'h0;
      $display("test pins done");
   endtask : t_pins
   task automatic t_dac;
      d1 = 8'h5a;
      d2 = 8'ha5;
      repeat (3) @(negedge clk);
      chk("dac1", l1, 8'h5a);
      chk("dac2", l2, 8'ha5);
      $display("test dac done");
   endtask : t_dac
   task automatic t_sec;
      mode = 1'b1;
      wr(8'h40);
      chk("ext_ref", 8'(xref), 8'h1);
      pls(2);
      chk("sec_lead", 8'({s_oe, s_q}), 8'h2);
      pls(3);
      chk("sec_match", 8'(s_oe), 8'h0);
      pls(3);
      chk("sec_lag", 8'({s_oe, s_q}), 8'h3);
      pls(2);
      pol = 1'b1;
      repeat (4) @(negedge clk);
      pls(2);
      chk("sec_inv", 8'({s_oe, s_q}), 8'h3);
      pls(3);
      wr(8'h08);
      chk("ext_ref", 8'(xref), 8'h0);
      pls(2);
      chk("sec_float", 8'(s_oe), 8'h0);
      pls(3);
      wr(8'h01);
      pls(2);
      chk("sec_stby", 8'(s_oe), 8'h0);
      pls(3);
      $display("test secondary done");
   endtask : t_sec
   task automatic t_main;
      mode = 1'b0;
      pol = 1'b0;
      wr(8'h02);
      wr(8'h10);
      repeat (50) @(negedge clk);
      chk("lock_unl", 8'(lock), 8'h0);
      wr(8'h00);
      pls(0);
      pls(1);
      repeat (5) @(negedge clk);
      chk("lock", 8'(lock), 8'h1);
      wr(8'h10);
      chk("lock_flt", 8'(lock), 8'h1);
      pls(0);
      chk("main_flt", 8'({h_oe, l_oe}), 8'h0);
      pls(1);
      wr(8'h00);
      pls(0);
      chk("main_on", 8'({h_oe, l_oe}), 8'h3);
      chk("main_sense", 8'({h_q, l_q}), 8'h0);
      wr(8'h10); // float set while the pulse runs
      chk("main_hold", 8'({h_oe, l_oe}), 8'h3);
      chk("lock_drift", 8'(lock), 8'h0);
      pls(1);
      pls(0);
      chk("main_flt2", 8'({h_oe, l_oe}), 8'h0);
      pls(1);
      $display("test main done");
   endtask : t_main
   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog, run needs well under 100 us
   initial
   begin
      #300000;
      mismatches++;
      wrap_up();
   end
   // reset for 16 cycles, then the tests
   initial
   begin
      rst_n = 1'b0;
      mode = 1'b0;
      pol = 1'b0;
      alt = 1'b0;
      a_sel = 2'h0;
      stb = 4'h0;
      d1 = 8'h00;
      d2 = 8'h00;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_pins();
      t_dac();
      t_sec();
      t_main();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
